// ===== src/fifo_status_consts.svh
// register offsets, field positions and reset values of the status group
`ifndef FIFO_STATUS_CONSTS_SVH
`define FIFO_STATUS_CONSTS_SVH
`define OFS_PRIMARY_FLAGS 8'h03
`define OFS_FIFO_DATA 8'h02
`define OFS_FIFO_FILL_COUNT 8'h04
`define OFS_SECONDARY_FLAGS 8'h05
`define OFS_IRQ_ENABLE_MASK 8'h06
`define OFS_FIFO_THRESHOLD 8'h29
`define FIFO_CAPACITY 7'h40
`define BIT_PENDING 3
`define BIT_ERROR_SUMMARY 2
`define BIT_NEARLY_FULL 1
`define BIT_NEARLY_EMPTY 0
`define BIT_TIMER_ACTIVE 7
`define BIT_EEPROM_DONE 6
`define BIT_CRC_DONE 5
`define BIT_WRITE_POLARITY 7
`define ENABLE_FIELD_MASK 8'h3F
`define RESET_FILL_COUNT 7'h00
`define RESET_ENABLE 6'h00
`define RESET_SECONDARY 8'h60
`define RESET_THRESHOLD 6'h08
`endif

// ===== src/fifo_status_pkg.sv
// types shared by the status and interrupt enable group
package fifo_status_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [5:0] enable_t;
endpackage

// ===== src/fifo_status_irq_enable.sv
// status registers, fifo fill counter and interrupt enable mask
`timescale 1ns/100ps
`default_nettype none
`include "fifo_status_consts.svh"

module fifo_status_irq_enable
  import fifo_status_pkg::*;
#(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] error_flag_register,
  input wire logic timer_active,
  input wire logic eeprom_write_done,
  input wire logic crc_done,
  input wire logic [2:0] rx_final_bit_count,
  input wire logic [5:0] irq_requests,
  output logic fifo_nearly_full,
  output logic fifo_nearly_empty,
  output logic irq_pending,
  output logic [6:0] fifo_fill_count
);

  enable_t irq_enable_mask;
  logic [5:0] fifo_threshold;
  byte_t secondary_flags;
  logic error_summary;
  logic fifo_push;
  logic fifo_pop;
  logic [6:0] next_fill;
  logic next_full;
  logic next_empty;
  logic next_pending;
  byte_t primary_flags;
  byte_t next_rdata;

  assign fifo_push = reg_write && reg_addr == `OFS_FIFO_DATA;
  assign fifo_pop = reg_read && reg_addr == `OFS_FIFO_DATA;

  always_comb begin
    next_fill = fifo_fill_count;
    if (fifo_push && !fifo_pop && fifo_fill_count < 7'(FIFO_DEPTH)) begin
      next_fill = fifo_fill_count + 7'h01;
    end else if (fifo_pop && !fifo_push && fifo_fill_count != 7'h00) begin
      next_fill = fifo_fill_count - 7'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_fill_count <= `RESET_FILL_COUNT;
    end else begin
      fifo_fill_count <= next_fill;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_threshold <= `RESET_THRESHOLD;
    end else if (reg_write && reg_addr == `OFS_FIFO_THRESHOLD) begin
      fifo_threshold <= reg_wdata[5:0];
    end
  end

  assign next_full = (`FIFO_CAPACITY - next_fill) <= {1'b0, fifo_threshold};
  assign next_empty = next_fill <= {1'b0, fifo_threshold};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_nearly_full <= 1'b0;
      fifo_nearly_empty <= 1'b1;
    end else begin
      fifo_nearly_full <= next_full;
      fifo_nearly_empty <= next_empty;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_mask <= `RESET_ENABLE;
    end else if (reg_write && reg_addr == `OFS_IRQ_ENABLE_MASK) begin
      if (reg_wdata[`BIT_WRITE_POLARITY]) begin
        irq_enable_mask <= irq_enable_mask | reg_wdata[5:0];
      end else begin
        irq_enable_mask <= irq_enable_mask & ~reg_wdata[5:0];
      end
    end
  end

  assign next_pending = |(irq_requests & irq_enable_mask);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pending <= 1'b0;
    end else begin
      irq_pending <= next_pending;
    end
  end

  assign error_summary = |error_flag_register;

  assign primary_flags = {4'h0, irq_pending, error_summary,
                          fifo_nearly_full, fifo_nearly_empty};

  assign secondary_flags = {timer_active, eeprom_write_done, crc_done,
                            2'b00, rx_final_bit_count};

  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      `OFS_PRIMARY_FLAGS: next_rdata = primary_flags;
      `OFS_FIFO_FILL_COUNT: next_rdata = {1'b0, fifo_fill_count};
      `OFS_SECONDARY_FLAGS: next_rdata = secondary_flags;
      `OFS_IRQ_ENABLE_MASK: next_rdata = {2'b00, irq_enable_mask};
      `OFS_FIFO_THRESHOLD: next_rdata = {2'b00, fifo_threshold};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  AST_PUSH_COUNTS: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    fifo_push && !fifo_pop && fifo_fill_count < 7'(FIFO_DEPTH)
    |=> fifo_fill_count == $past(fifo_fill_count) + 7'h01)
    else $error("fill count did not rise on push");

  AST_POP_COUNTS: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    fifo_pop && !fifo_push && fifo_fill_count != 7'h00
    |=> fifo_fill_count == $past(fifo_fill_count) - 7'h01)
    else $error("fill count did not fall on pop");

  AST_NEARLY_FULL: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    fifo_nearly_full == ((7'h40 - fifo_fill_count) <= {1'b0, fifo_threshold}))
    else $error("nearly full flag wrong");

  AST_NEARLY_EMPTY: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    fifo_nearly_empty == (fifo_fill_count <= {1'b0, fifo_threshold}))
    else $error("nearly empty flag wrong");

  AST_ENABLE_SET: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_write && reg_addr == 8'h06 && reg_wdata[7]
    |=> irq_enable_mask == ($past(irq_enable_mask) | $past(reg_wdata[5:0])))
    else $error("enable set write wrong");

  AST_ENABLE_CLEAR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_write && reg_addr == 8'h06 && !reg_wdata[7]
    |=> irq_enable_mask == ($past(irq_enable_mask) & ~$past(reg_wdata[5:0])))
    else $error("enable clear write wrong");

  AST_PENDING: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ##1 irq_pending == $past(|(irq_requests & irq_enable_mask)))
    else $error("pending bit wrong");

  AST_SECONDARY_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_read && reg_addr == 8'h05
    |=> reg_rdata[4:3] == 2'b00 && reg_rdata[7] == $past(timer_active))
    else $error("secondary flags read wrong");

  AST_ERROR_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_read && reg_addr == 8'h03
    |=> reg_rdata[2] == $past(|error_flag_register) && reg_rdata[7:4] == 4'h0)
    else $error("error summary read wrong");

  AST_ERROR_CLEAR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_read && reg_addr == `OFS_PRIMARY_FLAGS && error_flag_register == 8'h00
    |=> !reg_rdata[`BIT_ERROR_SUMMARY])
    else $error("error summary set without error");

  AST_FILL_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_read && reg_addr == `OFS_FIFO_FILL_COUNT
    |=> reg_rdata == {1'b0, $past(fifo_fill_count)})
    else $error("fill count read wrong");

  AST_FILL_BOUND: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    fifo_fill_count <= 7'(FIFO_DEPTH))
    else $error("fill count above depth");

  AST_PUSH_FULL_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    fifo_push && fifo_fill_count == 7'(FIFO_DEPTH)
    |=> fifo_fill_count == 7'(FIFO_DEPTH))
    else $error("fill count moved on push at full");

  AST_POP_EMPTY_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    fifo_pop && fifo_fill_count == 7'h00
    |=> fifo_fill_count == 7'h00)
    else $error("fill count moved on pop at empty");

  AST_FILL_IDLE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !fifo_push && !fifo_pop
    |=> $stable(fifo_fill_count))
    else $error("fill count moved without access");

  AST_ALERT_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_read && reg_addr == `OFS_PRIMARY_FLAGS
    |=> reg_rdata[1] == $past(fifo_nearly_full)
        && reg_rdata[0] == $past(fifo_nearly_empty))
    else $error("alert bits read wrong");

  AST_PENDING_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_read && reg_addr == `OFS_PRIMARY_FLAGS
    |=> reg_rdata[`BIT_PENDING] == $past(irq_pending))
    else $error("pending bit read wrong");

  AST_EEPROM_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_read && reg_addr == `OFS_SECONDARY_FLAGS
    |=> reg_rdata[`BIT_EEPROM_DONE] == $past(eeprom_write_done))
    else $error("eeprom done read wrong");

  AST_CRC_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_read && reg_addr == `OFS_SECONDARY_FLAGS
    |=> reg_rdata[`BIT_CRC_DONE] == $past(crc_done))
    else $error("crc done read wrong");

  AST_LAST_BITS_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_read && reg_addr == `OFS_SECONDARY_FLAGS
    |=> reg_rdata[2:0] == $past(rx_final_bit_count))
    else $error("last bit count read wrong");

  AST_ENABLE_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_read && reg_addr == `OFS_IRQ_ENABLE_MASK
    |=> reg_rdata == {2'b00, $past(irq_enable_mask)})
    else $error("enable mask read wrong");

  AST_ENABLE_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !(reg_write && reg_addr == `OFS_IRQ_ENABLE_MASK)
    |=> $stable(irq_enable_mask))
    else $error("enable mask changed without write");

  AST_PENDING_MASKED: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (irq_requests & irq_enable_mask) == 6'h00
    |=> !irq_pending)
    else $error("pending without enabled request");

  AST_RDATA_IDLE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !reg_read
    |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read");

  AST_UNMAPPED_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_read && !(reg_addr inside {8'h03, 8'h04, 8'h05, 8'h06, 8'h29})
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  AST_THRESHOLD_WRITE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_write && reg_addr == `OFS_FIFO_THRESHOLD
    |=> fifo_threshold == $past(reg_wdata[5:0]))
    else $error("threshold write wrong");

endmodule // fifo_status_irq_enable
`default_nettype wire

// ===== test/host_model.sv
// host side bus master for the status register group
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  initial begin
    {reg_addr, reg_wdata, reg_write, reg_read} = '0;
  end
  // one cycle per call, strobes exclusive
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
endmodule // host_model
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench of the status and enable register group
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fifo_status_pkg::*;
  logic core_clk = 0, rst_n = 0, reg_write, reg_read, rd_d = 0;
  logic timer_active = 0, eeprom_write_done = 1, crc_done = 1;
  logic fifo_nearly_full, fifo_nearly_empty, irq_pending;
  logic [7:0] reg_addr, reg_wdata, a_d, error_flag_register = '0;
  logic [2:0] rx_final_bit_count = '0;
  logic [5:0] irq_requests = '0, m = '0;
  logic [6:0] fifo_fill_count;
  byte_t reg_rdata, d, e, q[$];
  int n_fail = 0, samples_checked = 0, s = 44724, k, t = 8;
  always #2.5 core_clk = ~core_clk;
  fifo_status_irq_enable fifo_status_irq_enable_i (.core_clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .error_flag_register, .timer_active, .eeprom_write_done, .crc_done,
    .rx_final_bit_count, .irq_requests, .fifo_nearly_full,
    .fifo_nearly_empty, .irq_pending, .fifo_fill_count);
  host_model host_model_i (.core_clk, .reg_addr, .reg_wdata, .reg_write,
    .reg_read);
  function automatic byte_t xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  task automatic chk(string n, byte_t x, byte_t g);
    samples_checked++;
    if (x !== g) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rdx(byte_t a, byte_t x);
    host_model_i.bus(0, 1, a, 0);
    q.push_back(x);
  endtask
  task automatic step(logic w, int n);
    host_model_i.bus(w, !w, 8'h02, xs());
    #1;
    chk("fill", 8'(n), {1'b0, fifo_fill_count});
    chk("empty", 8'(n <= t), 8'(fifo_nearly_empty));
    chk("full", 8'(64 - n <= t), 8'(fifo_nearly_full));
  endtask
  // read data checked in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_d && a_d != 8'h02)
      chk("rdata", q.pop_front(), reg_rdata);
    rd_d <= reg_read;
    a_d <= reg_addr;
  end
  initial begin
    #20000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1;
    @(posedge core_clk);
    rdx(8'h04, 8'h00);
    rdx(8'h06, 8'h00);
    rdx(8'h05, 8'h60);
    rdx(8'h03, 8'h01);
    host_model_i.bus(1, 0, 8'h05, 8'hFF);
    rdx(8'h05, 8'h60);
    rdx(8'h7F, 8'h00);
    for (k = 0; k < 4; k++) begin
      d = xs();
      {timer_active, eeprom_write_done, crc_done} <= d[7:5];
      rx_final_bit_count <= d[2:0];
      host_model_i.bus(0, 0, 0, 0);
      rdx(8'h05, d & 8'hE7);
    end
    for (k = 1; k <= 65; k++)
      step(1, k > 64 ? 64 : k);
    rdx(8'h04, 8'h40);
    host_model_i.bus(1, 0, 8'h29, 8'hC4);
    t = 4;
    rdx(8'h29, 8'h04);
    for (k = 63; k >= -1; k--)
      step(0, k < 0 ? 0 : k);
    for (k = 0; k < 10; k++) begin
      d = k == 0 ? 8'hBF : k == 1 ? 8'h15 : xs();
      host_model_i.bus(1, 0, 8'h06, d);
      m = d[7] ? m | d[5:0] : m & ~d[5:0];
      e = xs();
      irq_requests <= e[5:0];
      rdx(8'h06, {2'b00, m});
      #1;
      chk("pending", 8'(|(m & e[5:0])), 8'(irq_pending));
    end
    irq_requests <= '0;
    for (k = 0; k < 9; k++) begin
      error_flag_register <= 8'(9'h001 << k);
      host_model_i.bus(0, 0, 0, 0);
      rdx(8'h03, k < 8 ? 8'h05 : 8'h01);
    end
    host_model_i.bus(0, 0, 0, 0);
    host_model_i.bus(0, 0, 0, 0);
    conclude();
  end
endmodule // testbench
`default_nettype wire
